// ==== core/tsp_top.sv ====
// Timed serial I/O ports, clock blocks, pin multiplex and AHB-Lite slave.
// Assumes pins and strobes are asynchronous; bus is on core_clk.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module tsp_top import tsp_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  output logic [NPIN-1:0] pin_pulldown,
  // Strobes and events
  input wire logic [NP-1:0] strobe_in,
  output logic [NP-1:0] output_strobe,
  output logic [NP-1:0] port_event
);
  // Register state
  logic [31:0] ctrl [NP]; // Port control
  logic [31:0] cond [NP]; // Condition value
  logic [31:0] cbreg [NCB]; // Clock block setup
  logic link_en; // Link owns its pins
  // Bus data phase
  logic dp_wr; // Write pending
  logic [7:0] dp_addr; // Latched address
  logic aph; // Valid address phase
  logic [31:0] next_rdata; // Read mux
  // Synchronisers
  logic [NPIN-1:0] pin_s1, pin_s2, pin_s3;
  logic [NP-1:0] stb_s1, stb_s2;
  // Clock blocks
  logic [NCB-1:0] cb_tick; // One-cycle rates
  logic [7:0] cb_div [NCB]; // Divider counts
  // Pin ownership
  logic [NPIN-1:0] next_out, next_oe;
  // Port links
  tsp_port_if pif [NP] ();
  logic [31:0] p_rx [NP];
  logic [15:0] p_cnt [NP];
  logic [15:0] p_stamp [NP];
  logic [NP-1:0] p_rxv, p_txf, p_stb, p_evt;
  logic [31:0] p_val [NP];
  logic [31:0] p_en [NP];

  assign aph = hsel && htrans[1] && hready;

  // Bus phase tracking
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_wr <= aph && hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read mux, decoded in the address phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int n = 0; n < NP; n++) begin
      if (haddr[7:5] == 3'(n)) begin
        case (haddr[4:0])
          OFS_CTRL: begin
            next_rdata = ctrl[n];
            next_rdata[CTL_RXV] = p_rxv[n];
            next_rdata[CTL_TXF] = p_txf[n];
          end
          OFS_DATA: next_rdata = p_rx[n];
          OFS_TIME: next_rdata = {16'h0000, p_cnt[n]};
          OFS_STAMP: next_rdata = {16'h0000, p_stamp[n]};
          OFS_COND: next_rdata = cond[n];
          default: next_rdata = 32'h0000_0000;
        endcase
      end
    end
    for (int k = 0; k < NCB; k++) begin
      if (haddr[7:0] == CB_BASE + 8'(4 * k)) begin
        next_rdata = cbreg[k];
      end
    end
    if (haddr[7:0] == LINK_ADDR) begin
      next_rdata = {31'h0000_0000, link_en};
    end
  end

  // Read data stands through the data phase
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (aph && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // Port control and condition writes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int n = 0; n < NP; n++) begin
        ctrl[n] <= CTRL_RST;
        cond[n] <= 32'h0000_0000;
      end
    end else if (dp_wr) begin
      for (int n = 0; n < NP; n++) begin
        if (dp_addr[7:5] == 3'(n) && dp_addr[4:0] == OFS_CTRL) begin
          // Status bits are read-only
          ctrl[n] <= {2'b00, hwdata[29:0]};
        end
        if (dp_addr[7:5] == 3'(n) && dp_addr[4:0] == OFS_COND) begin
          cond[n] <= hwdata;
        end
      end
    end
  end

  // Clock block and link writes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < NCB; k++) begin
        cbreg[k] <= CB_RST;
      end
      link_en <= 1'b0;
    end else if (dp_wr) begin
      for (int k = 1; k < NCB; k++) begin
        if (dp_addr == CB_BASE + 8'(4 * k)) begin
          cbreg[k] <= hwdata;
        end
      end
      if (dp_addr == LINK_ADDR) begin
        link_en <= hwdata[0];
      end
    end
  end

  // Two-flop pin and strobe synchronisers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      stb_s1 <= '0;
      stb_s2 <= '0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      stb_s1 <= strobe_in;
      stb_s2 <= stb_s1;
    end
  end

  assign cb_tick[0] = 1'b1;
  assign cb_div[0] = 8'h00;
  generate
    for (genvar k = 1; k < NCB; k++) begin : g_cb
      logic src_edge; // Source event
      logic [7:0] divn; // Divide count
      logic tk; // Registered rate
      always_comb begin
        if (cbreg[k][CB_SRC]) begin
          src_edge = cbreg[k][CB_PSEL] ? (pin_s2[PB[1]] && !pin_s3[PB[1]]) : (pin_s2[PB[0]] && !pin_s3[PB[0]]);
        end else begin
          src_edge = 1'b1;
        end
      end
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          divn <= 8'h00;
          tk <= 1'b0;
        end else begin
          tk <= 1'b0;
          if (src_edge) begin
            if (divn >= cbreg[k][CB_DIV +: 8]) begin
              divn <= 8'h00;
              tk <= 1'b1;
            end else begin
              divn <= divn + 8'h01;
            end
          end
        end
      end
      assign cb_tick[k] = tk;
      assign cb_div[k] = divn;
    end
  endgenerate

  generate
    for (genvar n = 0; n < NP; n++) begin : g_port
      logic [31:0] pins;
      always_comb begin
        pins = 32'h0000_0000;
        for (int i = 0; i < PW[n]; i++) begin
          pins[i] = pin_s2[PB[n] + i];
        end
      end
      assign pif[n].tick = cb_tick[ctrl[n][CTL_CB +: 3] < 3'(NCB) ? ctrl[n][CTL_CB +: 3] : 3'h0];
      assign pif[n].pins_in = pins;
      assign pif[n].strobe_in = stb_s2[n];
      assign pif[n].ctrl = ctrl[n];
      assign pif[n].cond = cond[n];
      assign pif[n].wdata = hwdata;
      assign pif[n].data_wr = dp_wr && dp_addr[7:5] == 3'(n) && dp_addr[4:0] == OFS_DATA;
      assign pif[n].time_wr = dp_wr && dp_addr[7:5] == 3'(n) && dp_addr[4:0] == OFS_TIME;
      assign pif[n].data_rd = aph && !hwrite && haddr[7:5] == 3'(n) && haddr[4:0] == OFS_DATA;
      assign p_rx[n] = pif[n].rx_data;
      assign p_cnt[n] = pif[n].count;
      assign p_stamp[n] = pif[n].stamp;
      assign p_rxv[n] = pif[n].rx_valid;
      assign p_txf[n] = pif[n].tx_full;
      assign p_val[n] = pif[n].drv_val;
      assign p_en[n] = pif[n].drv_en;
      assign p_stb[n] = pif[n].strobe_out;
      assign p_evt[n] = pif[n].event_p;
      tsp_port #(.W(PW[n])) u_port (
        .core_clk(core_clk),
        .reset(reset),
        .pif(pif[n])
      );
    end
  endgenerate

  // Pin ownership, ports ordered narrowest first
  always_comb begin
    next_out = '0;
    next_oe = '0;
    for (int p = 0; p < NPIN; p++) begin
      logic taken;
      taken = 1'b0;
      if (link_en && LINK_PINS[p]) begin
        taken = 1'b1;
      end
      for (int n = 0; n < NP; n++) begin
        if (!taken && ctrl[n][CTL_EN] && p >= PB[n] && p < PB[n] + PW[n]) begin
          taken = 1'b1;
          next_out[p] = p_val[n][p - PB[n]];
          next_oe[p] = p_en[n][p - PB[n]];
        end
      end
    end
  end

  // Registered pin drive
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_pulldown <= '1;
    end else begin
      pin_pulldown <= ~next_oe;
    end
  end

  // events and strobes to the tile
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      output_strobe <= '0;
      port_event <= '0;
    end else begin
      output_strobe <= p_stb;
      port_event <= p_evt;
    end
  end
endmodule // tsp_top

// ==== common/tsp_pkg.sv ====
// Constants, register map and types for the timed serial I/O port block.
// Assumes a single core clock domain and an AHB-Lite register bus.
// Behaviour
// - Port widths fixed at 1, 4, 8, 16, 32; the four ports here are 1, 1, 4, 8 wide
// - All pins of a port share direction
// - Drive high/low or sample, optional condition
// - Each port access completes in one cycle
// - Open-drain: zero pulls low, one releases
// - Open-drain selected per port, all pins
// - Data passes serdes plus transfer register
// - 16-bit counter schedules each transfer
// - Counter readable; transfers deferrable to count
// - Transfer captures counter as timestamp
// - Enabled link disables port on its pins
// - Narrower enabled port wins shared pins
// - Unshared pins stay with wider port
// - Port keeps nominal width when overruled
// - Six clock blocks; block zero is reference
// - Clock block may use 1-bit port source
// - Clock block optionally divides pin clock
// - Input ready strobe qualifies sampled data
// - Port generates output strobe with data
// - Reset attaches every port to block zero
// - Pin conditions delivered as events
// - Pull-downs enabled while in reset
package tsp_pkg;
  // Geometry
  localparam int NP = 4;
  localparam int NPIN = 8;
  localparam int NCB = 6;
  localparam int PW [NP] = '{1, 1, 4, 8};
  localparam int PB [NP] = '{0, 1, 4, 0};
  localparam logic [NPIN-1:0] LINK_PINS = 8'h03;
  // Register map, port n at n * PORT_STRIDE
  localparam logic [7:0] PORT_STRIDE = 8'h20;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_DATA = 5'h04;
  localparam logic [4:0] OFS_TIME = 5'h08;
  localparam logic [4:0] OFS_STAMP = 5'h0C;
  localparam logic [4:0] OFS_COND = 5'h10;
  localparam logic [7:0] CB_BASE = 8'h80;
  localparam logic [7:0] LINK_ADDR = 8'hA0;
  // Port control fields
  localparam int CTL_EN = 0;
  localparam int CTL_OUT = 1;
  localparam int CTL_OD = 2;
  localparam int CTL_CMODE = 4;
  localparam int CTL_SIN = 7;
  localparam int CTL_SOUT = 8;
  localparam int CTL_CB = 12;
  localparam int CTL_RXV = 30;
  localparam int CTL_TXF = 31;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Clock block fields
  localparam int CB_SRC = 0;
  localparam int CB_PSEL = 1;
  localparam int CB_DIV = 8;
  localparam logic [31:0] CB_RST = 32'h0000_0000;
  // Sampling condition modes
  typedef enum logic [1:0] {TSP_C_NONE = 2'h0, TSP_C_EQ = 2'h1, TSP_C_NE = 2'h2} tsp_cmode_e;
  // Port sequencer states
  typedef enum logic [1:0] {TSP_IDLE = 2'h0, TSP_SHIFT = 2'h1} tsp_state_e;
endpackage

// ==== common/tsp_port_if.sv ====
// Carrier between the register/pin logic and one port engine.
// Assumes both ends run on core_clk.
`timescale 1ns/10ps
interface tsp_port_if;
  logic tick;
  logic [31:0] pins_in;
  logic strobe_in;
  logic [31:0] ctrl;
  logic [31:0] cond;
  logic [31:0] wdata;
  logic data_wr;
  logic data_rd;
  logic time_wr;
  logic [31:0] rx_data;
  logic [15:0] count;
  logic [15:0] stamp;
  logic rx_valid;
  logic tx_full;
  logic [31:0] drv_val;
  logic [31:0] drv_en;
  logic strobe_out;
  logic event_p;
  modport ctl (output tick, pins_in, strobe_in, ctrl, cond, wdata, data_wr, data_rd, time_wr,
               input rx_data, count, stamp, rx_valid, tx_full, drv_val, drv_en, strobe_out, event_p);
  modport port (input tick, pins_in, strobe_in, ctrl, cond, wdata, data_wr, data_rd, time_wr,
                output rx_data, count, stamp, rx_valid, tx_full, drv_val, drv_en, strobe_out, event_p);
endinterface // tsp_port_if

// ==== core/tsp_port.sv ====
// One port engine: transfer register, serdes, counter, timestamp.
// Assumes tick is a one-cycle enable from the selected clock block.
`timescale 1ns/10ps
module tsp_port import tsp_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Link to the register logic
  tsp_port_if.port pif
);
  localparam int NS = 32 / W;
  localparam logic [5:0] NS_M1 = 6'(NS - 1);
  localparam logic [5:0] NS_M2 = 6'(NS > 1 ? NS - 2 : 0);
  tsp_state_e state; // Sequencer
  logic [31:0] xfer; // Transfer register
  logic [31:0] sh; // Serdes shift register
  logic [5:0] slice; // Slices left
  logic [15:0] cnt; // Port counter
  logic [15:0] sched; // Scheduled count
  logic armed; // Timed transfer pending
  logic [W-1:0] oval; // Value on the pins
  logic [31:0] shin; // Serdes after one sample
  logic [63:0] cat; // Shift helper
  logic en, dout, od, sin, sout, time_ok, cond_ok, stb_ok;
  logic [W-1:0] pins, cval;
  tsp_cmode_e cm;
  // Field decode
  always_comb begin
    en = pif.ctrl[CTL_EN];
    dout = pif.ctrl[CTL_OUT];
    od = pif.ctrl[CTL_OD];
    sin = pif.ctrl[CTL_SIN];
    sout = pif.ctrl[CTL_SOUT];
    cm = tsp_cmode_e'(pif.ctrl[CTL_CMODE +: 2]);
    pins = pif.pins_in[W-1:0];
    cval = pif.cond[W-1:0];
    cat = {pif.pins_in, sh} >> W;
    shin = cat[31:0];
    time_ok = !armed || (cnt == sched);
    cond_ok = (cm == TSP_C_NONE) || (cm == TSP_C_EQ && pins == cval) || (cm == TSP_C_NE && pins != cval);
    stb_ok = !sin || pif.strobe_in;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt <= 16'h0000;
    end else if (pif.tick) begin
      cnt <= cnt + 16'h0001;
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sched <= 16'h0000;
      armed <= 1'b0;
    end else if (pif.time_wr) begin
      sched <= pif.wdata[15:0];
      armed <= 1'b1;
    end else if (pif.tick && en && state == TSP_IDLE && time_ok && (dout ? pif.tx_full : cond_ok && stb_ok)) begin
      armed <= 1'b0;
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= TSP_IDLE;
      xfer <= 32'h0000_0000;
      sh <= 32'h0000_0000;
      slice <= 6'h00;
      oval <= '0;
      pif.stamp <= 16'h0000;
      pif.tx_full <= 1'b0;
      pif.rx_valid <= 1'b0;
      pif.strobe_out <= 1'b0;
      pif.event_p <= 1'b0;
    end else begin
      pif.strobe_out <= 1'b0;
      pif.event_p <= 1'b0;
      // Software read empties the input side
      if (pif.data_rd) begin
        pif.rx_valid <= 1'b0;
      end
      // Software write fills the output side
      if (pif.data_wr && dout) begin
        xfer <= pif.wdata;
        pif.tx_full <= 1'b1;
      end
      if (!en) begin
        // Disabled port rests
        state <= TSP_IDLE;
      end else if (pif.tick) begin
        case (state)
          TSP_IDLE: begin
            if (dout && pif.tx_full && time_ok) begin
              pif.stamp <= cnt;
              sh <= xfer >> W;
              oval <= xfer[W-1:0];
              slice <= NS_M1;
              state <= (NS > 1) ? TSP_SHIFT : TSP_IDLE;
              // Set by write beats the clear
              if (!pif.data_wr) begin
                pif.tx_full <= 1'b0;
              end
              pif.strobe_out <= sout;
            end else if (!dout && time_ok && cond_ok && stb_ok) begin
              sh <= shin;
              slice <= NS_M2;
              pif.event_p <= (cm != TSP_C_NONE);
              if (NS == 1) begin
                xfer <= shin;
                pif.stamp <= cnt;
                pif.rx_valid <= 1'b1;
                pif.event_p <= 1'b1;
              end else begin
                state <= TSP_SHIFT;
              end
            end
          end
          TSP_SHIFT: begin
            if (dout) begin
              oval <= sh[W-1:0];
              sh <= sh >> W;
              pif.strobe_out <= sout;
              slice <= slice - 6'h01;
              if (slice == 6'h01) begin
                state <= TSP_IDLE;
              end
            end else if (stb_ok) begin
              sh <= shin;
              slice <= slice - 6'h01;
              if (slice == 6'h00) begin
                xfer <= shin;
                pif.stamp <= cnt;
                pif.rx_valid <= 1'b1;
                pif.event_p <= 1'b1;
                state <= TSP_IDLE;
              end
            end
          end
          default: state <= TSP_IDLE;
        endcase
      end
    end
  end
  // Pin drive and read-back
  always_comb begin
    pif.rx_data = xfer;
    pif.count = cnt;
    pif.drv_val = 32'h0000_0000;
    pif.drv_en = 32'h0000_0000;
    if (en && dout) begin
      pif.drv_val[W-1:0] = od ? '0 : oval;
      pif.drv_en[W-1:0] = od ? ~oval : '1;
    end
  end
endmodule // tsp_port

// ==== testbench/tsp_top_properties.sv ====
// Checker for the timed port top, bound by name.
// Assumes it sees only the top ports, one clock domain.
`timescale 1ns/10ps
module tsp_top_properties import tsp_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins, strobes, events
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] pin_pulldown,
  input wire logic [NP-1:0] output_strobe,
  input wire logic [NP-1:0] port_event
);
  // Read address phase taken
  logic rd_take;
  // Link write in data phase
  logic link_wr;
  // Shadow of link enable
  logic link_on;
  assign rd_take = hsel & htrans[1] & hready & ~hwrite;
  // Track link enable writes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      link_wr <= 1'b0;
      link_on <= 1'b0;
    end else begin
      link_wr <= hsel & htrans[1] & hready & hwrite & (haddr[7:0] == LINK_ADDR);
      if (link_wr) begin
        link_on <= hwdata[0];
      end
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  bus_ready_a: assert property (hreadyout && rd_take |=> hreadyout) else $error("wait state inserted");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  rdata_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata)) else $error("read data moved");
  pd_reset_a: assert property (disable iff (1'b0) reset |-> &pin_pulldown && pin_oe == '0)
    else $error("pins not pulled down in reset");
  pd_driven_a: assert property ((pin_pulldown & pin_oe & $past(pin_oe)) == '0) else $error("driven pin pulled");
  link_pins_a: assert property (link_on && $past(link_on, 4) |-> pin_oe[1:0] == 2'b00)
    else $error("link pins still driven");
  dir_excl_a: assert property ((output_strobe & port_event) == '0)
    else $error("port drove and captured at once");
  quiet_release_a: assert property ($fell(reset) |-> output_strobe == '0 && port_event == '0)
    else $error("strobe or event after reset");
  cover property (output_strobe[2]);
  cover property (port_event[2]);
  cover property (link_on && pin_oe[1:0] == 2'b00);
endmodule // tsp_top_properties

bind tsp_top tsp_top_properties i_props (.core_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .pin_oe, .pin_pulldown, .output_strobe, .port_event);

// ==== testbench/tsp_pin_partner.sv ====
// Pin-side hardware: application clock on pin 0, data drive, pulls.
// Assumes the bench steers it after core clock edges.
`timescale 1ns/10ps
module tsp_pin_partner import tsp_pkg::*; (
  // Controls
  input wire logic run_clk,
  input wire logic [NPIN-1:0] ext_en,
  input wire logic [NPIN-1:0] ext_val,
  // Device pins
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] pin_pulldown,
  output logic [NPIN-1:0] pin_in
);
  // Application clock, still outside frames
  logic app_clk = 1'b0;
  // Pins the partner drives
  logic [NPIN-1:0] msk;
  // Level the partner drives
  logic [NPIN-1:0] lvl;
  // external clock for a clock block
  always #370 app_clk = run_clk & ~app_clk;
  assign msk = ext_en | {7'h0, run_clk};
  assign lvl = {ext_val[7:1], run_clk ? app_clk : ext_val[0]};
  // released pin falls to its pull level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & msk & lvl) | (~pin_oe & ~msk & ~pin_pulldown);
endmodule // tsp_pin_partner

// ==== testbench/tsp_top_tb_top.sv ====
// Self-checking bench for the timed port top.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/10ps
module tsp_top_tb_top import tsp_pkg::*;;
  logic core_clk = 1'b0;
  logic reset = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [NP-1:0] strobe_in = '0;
  logic run_clk = 1'b0;
  logic [7:0] ext_en = '0;
  logic [7:0] ext_val = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pulldown;
  logic [NP-1:0] ostb, pev;
  int bad_count = 0;
  int comparisons = 0;
  int seed = 62700;
  int gap = 0;
  // Notes: {mask, value} reads, {oe, driven value} pins
  logic [63:0] rd_q[$];
  logic [15:0] pin_q[$];
  logic rd_ph = 1'b0;
  logic pin_chk = 1'b0;
  logic snap = 1'b0;
  logic [3:0] sh = '0;
  logic [31:0] t, d;
  logic [7:0] b;
  logic [3:0] nib;

  always #50 core_clk = ~core_clk;

  tsp_top i_dut (.core_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe, .pin_pulldown, .strobe_in, .output_strobe(ostb),
    .port_event(pev));
  tsp_pin_partner i_far (.run_clk, .ext_en, .ext_val, .pin_out, .pin_oe, .pin_pulldown, .pin_in);

  // Count and report one comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Condition polled by bounded waits
  function automatic logic hit(input int w);
    case (w)
      0: return pin_q.size() == 0;
      1: return pev[2] === 1'b1;
      2: return ostb[2] === 1'b1;
      default: return hreadyout === 1'b1;
    endcase
  endfunction
  // Bounded wait, timeout ends the run
  task automatic await(input int w, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!hit(w) && n < lim);
    if (n >= lim) begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Port register byte address
  function automatic logic [7:0] pa(input int n, input logic [4:0] o);
    return 8'(n) * PORT_STRIDE + {3'h0, o};
  endfunction
  // One AHB-Lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    await(3, 64);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    await(3, 64);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] q;
    bus(1'b1, a, v, q);
  endtask
  // Read with the expected value noted first
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] q);
    rd_q.push_back({m, e});
    bus(1'b0, a, 32'h0, q);
  endtask
  // One pin snapshot against the oldest note
  task automatic peek();
    snap <= 1'b1;
    @(posedge core_clk);
    snap <= 1'b0;
    @(posedge core_clk);
  endtask

  // Result watcher: read data and pin slices
  always @(posedge core_clk) begin
    logic [63:0] e;
    if (rd_ph && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      check(hrdata & e[63:32], e[31:0] & e[63:32]);
    end
    rd_ph <= hsel & htrans[1] & hreadyout & ~hwrite;
    sh <= {sh[2:0], ostb[2] & pin_chk};
    gap <= ostb[2] ? 0 : gap + 1;
    if (ostb[2] && pin_chk && gap < 30) check(32'(gap >= 12), 32'h1);
    if ((sh[3] || snap) && pin_q.size() > 0) check({16'h0, pin_oe, pin_out & pin_oe}, {16'h0, pin_q.pop_front()});
  end

  // Main sequence
  initial begin
    int n, k;
    reset <= 1'b1;
    cyc(6);
    reset <= 1'b0;
    @(posedge core_clk);
    for (n = 0; n < NP; n++) rd(pa(n, OFS_CTRL), 32'h0, 32'hFFFF_FFFF, t);
    wr(CB_BASE, 32'hFFFF_FFFF);
    rd(CB_BASE, 32'h0, 32'hFFFF_FFFF, t);
    rd(8'hFC, 32'h0, 32'hFFFF_FFFF, t);
    // Deferred output on block zero, stamped at the armed count
    wr(pa(2, OFS_CTRL), 32'h0000_0103);
    rd(pa(2, OFS_TIME), 32'h0, 32'hFFFF_0000, t);
    rd(pa(2, OFS_TIME), t + 32'd2, 32'h0000_FFFF, t);
    wr(pa(2, OFS_TIME), {16'h0, 16'(t + 32'd40)});
    wr(pa(2, OFS_DATA), $random(seed));
    await(2, 200);
    rd(pa(2, OFS_STAMP), t + 32'd40, 32'h0000_FFFF, t);
    wr(pa(2, OFS_CTRL), 32'h0);
    // Serial output on a divided pin clock, push-pull then open-drain
    wr(CB_BASE + 8'h04, 32'h0000_0101);
    run_clk <= 1'b1;
    pin_chk <= 1'b1;
    for (n = 0; n < 2; n++) begin
      d = $random(seed);
      wr(pa(2, OFS_CTRL), 32'h0000_1103 | (32'(n) << 2));
      for (k = 0; k < 8; k++) pin_q.push_back(n != 0 ? {~d[4*k+:4], 12'h0} : {8'hF0, d[4*k+:4], 4'h0});
      wr(pa(2, OFS_DATA), d);
      await(0, 800);
    end
    pin_chk <= 1'b0;
    run_clk <= 1'b0;
    // Strobe-qualified capture on pins 4 to 7
    nib = 4'($random(seed));
    ext_en <= 8'hF0;
    ext_val <= {nib, 4'h0};
    wr(pa(2, OFS_CTRL), 32'h0000_0081);
    cyc(60);
    rd(pa(2, OFS_CTRL), 32'h0, 32'h4000_0000, t);
    strobe_in <= 4'h4;
    await(1, 200);
    strobe_in <= 4'h0;
    rd(pa(2, OFS_CTRL), 32'h4000_0000, 32'h4000_0000, t);
    rd(pa(2, OFS_DATA), {8{nib}}, 32'hFFFF_FFFF, t);
    rd(pa(2, OFS_CTRL), 32'h0, 32'h4000_0000, t);
    wr(pa(2, OFS_CTRL), 32'h0);
    // Condition-gated capture: mismatch holds off, match captures
    wr(pa(2, OFS_COND), {28'h0, ~nib});
    wr(pa(2, OFS_CTRL), 32'h0000_0011);
    cyc(40);
    rd(pa(2, OFS_CTRL), 32'h0, 32'h4000_0000, t);
    wr(pa(2, OFS_COND), {28'h0, nib});
    await(1, 200);
    cyc(12);
    rd(pa(2, OFS_CTRL), 32'h4000_0000, 32'h4000_0000, t);
    wr(pa(2, OFS_CTRL), 32'h0);
    ext_en <= 8'h00;
    // Narrow port wins pin 0, link then takes pins 0 and 1
    b = 8'($random(seed));
    wr(pa(3, OFS_CTRL), 32'h3);
    wr(pa(3, OFS_DATA), {4{b}});
    wr(pa(0, OFS_CTRL), 32'h3);
    wr(pa(0, OFS_DATA), 32'hFFFF_FFFF);
    cyc(80);
    pin_q.push_back({8'hFF, b[7:1], 1'b1});
    peek();
    wr(LINK_ADDR, 32'h1);
    cyc(10);
    pin_q.push_back({8'hFC, b[7:2], 2'b00});
    peek();
    // Second reset in mid-run
    reset <= 1'b1;
    cyc(6);
    check({24'h0, pin_pulldown}, 32'h0000_00FF);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(pa(3, OFS_CTRL), 32'h0, 32'hFFFF_FFFF, t);
    rd(LINK_ADDR, 32'h0, 32'hFFFF_FFFF, t);
    cyc(4);
    stop_test();
  end
endmodule // tsp_top_tb_top
